// ===== rtl/cksel_pkg.sv
// Constants, field layout and carrier types of the clock select block
`default_nettype none
package cksel_pkg;
  localparam logic [7:0] OFS_STABILITY = 8'h0C;
  localparam logic [7:0] OFS_CORE_SEL  = 8'h10;
  localparam logic [7:0] OFS_PERIPH_A  = 8'h14;
  localparam logic [7:0] OFS_DIVIDE    = 8'h18;
  localparam logic [7:0] OFS_PERIPH_B  = 8'h1C;
  localparam logic [7:0] OFS_SYNTH     = 8'h20;
  localparam logic [7:0] OFS_UNLOCK    = 8'h30;

  localparam logic [7:0] UNLOCK_KEY_1 = 8'h59;
  localparam logic [7:0] UNLOCK_KEY_2 = 8'h16;
  localparam logic [7:0] UNLOCK_KEY_3 = 8'h88;

  localparam logic [31:0] SEL_RESET    = 32'hFFFFFFFF;
  localparam logic [31:0] DIV_RESET    = 32'h00000000;
  localparam logic [31:0] SYNTH_RESET  = 32'h0005C22E;
  localparam logic [2:0]  CORE_RESET   = 3'h7;
  localparam logic [31:0] PA_MASK      = 32'hF377770F;
  localparam logic [31:0] PB_MASK      = 32'h000000FC;
  localparam logic [31:0] DIV_MASK     = 32'h00FF0F0F;
  localparam logic [31:0] SYNTH_MASK   = 32'h000FFFFF;

  localparam int FAIL_BIT = 7;
  localparam int FAST_STB_BIT = 4;
  localparam int SLOW_STB_BIT = 3;
  localparam int SYNTH_STB_BIT = 2;
  localparam int XTAL_STB_BIT = 0;
  localparam int REF_SEL_BIT = 19;
  localparam int GATE_BIT = 18;
  localparam int PASS_BIT = 17;
  localparam int SLEEP_BIT = 16;

  localparam int WDOG_DIVIDE = 2048;
  localparam int CLK_PERIOD_NS = 40;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cksel_bus_type;

  // Sampled clock levels and their stability indications
  typedef struct packed {
    logic crystal;
    logic fast;
    logic slow;
    logic synth;
  } cksel_src_type;

  typedef enum logic [1:0] {
    LOCKED,
    GOT_KEY_1,
    GOT_KEY_2,
    OPEN
  } cksel_lock_type;
endpackage
`default_nettype wire

// ===== rtl/cksel_top.sv
// Clock source selection, dividers and synthesizer control registers
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module cksel_top
  import cksel_pkg::*;
#(
  parameter int CORE_DIV_W = 4,
  parameter int UART_DIV_W = 4,
  parameter int ADC_DIV_W  = 8
) (
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  input  wire logic          ce_in,
  input  wire cksel_bus_type bus_in,
  input  wire cksel_src_type level_in,
  input  wire cksel_src_type stable_in,
  input  wire logic [3:0]    ext_trigger_in,
  input  wire logic          chip_sleep_req_in,
  input  wire logic [2:0]    boot_oscillator_config_in,
  output logic [31:0]        rd_data_out,
  output logic               core_clk_out,
  output logic               core_tick_out,
  output logic               tick_clk_out,
  output logic               uart_tick_out,
  output logic               adc_tick_out,
  output logic [3:0]         pwm_clk_out,
  output logic [3:0]         timer_clk_out,
  output logic               watchdog_clk_out,
  output logic               freq_div_clk_out,
  output logic               synth_ref_clk_out,
  output logic               synth_clk_out,
  output logic               synth_sleep_out,
  output logic [9:0]         synth_fb_factor_out,
  output logic [5:0]         synth_in_factor_out,
  output logic [2:0]         synth_out_factor_out
);

  // Three-bit source pick; code 001 yields a quiet low level
  function automatic logic sel3(input logic [2:0] c, input logic a0,
                                input logic a2, input logic a3,
                                input logic a4);
    logic r;
    r = 1'b0;
    if (c[2]) begin
      r = a4;
    end else if (c == 3'h2) begin
      r = a2;
    end else if (c == 3'h3) begin
      r = a3;
    end else if (c == 3'h0) begin
      r = a0;
    end
    return r;
  endfunction

  function automatic logic sel2(input logic [1:0] c, input logic a0,
                                input logic a1, input logic a2,
                                input logic a3);
    logic r;
    r = a0;
    if (c == 2'h1) begin
      r = a1;
    end else if (c == 2'h2) begin
      r = a2;
    end else if (c == 2'h3) begin
      r = a3;
    end
    return r;
  endfunction

  // Returns {tick, next count}; wraps once count reaches the limit
  function automatic logic [8:0] div_step(input logic rise,
                                          input logic [7:0] cnt,
                                          input logic [7:0] lim);
    logic [8:0] r;
    r = {1'b0, cnt};
    if (rise) begin
      if (cnt >= lim) begin
        r = {1'b1, 8'h00};
      end else begin
        r = {1'b0, 8'(cnt + 8'h01)};
      end
    end
    return r;
  endfunction

  logic [5:0]     core_sel_q;
  logic [31:0]    pa_q;
  logic [31:0]    pb_q;
  logic [31:0]    div_q;
  logic [31:0]    synth_q;
  logic           fail_q;
  logic           boot_done_q;
  cksel_lock_type lock_q;
  logic [2:0]     core_active_q;
  cksel_src_type  prev_q;
  logic           xtal_half_q;
  logic           fast_half_q;
  logic           core_half_q;
  logic [7:0]     core_cnt_q;
  logic [7:0]     uart_cnt_q;
  logic [7:0]     adc_cnt_q;
  logic [9:0]     wdog_cnt_q;
  logic           wdog_lvl_q;
  logic           uart_src_prev_q;
  logic           adc_src_prev_q;
  logic           core_src_prev_q;

  logic        wr_core;
  logic        wr_unlock;
  logic        unlocked;
  logic [2:0]  core_req;
  logic        req_ok;
  logic        fail_set;
  logic        synth_ref;
  logic        synth_lvl;
  logic        core_src;
  logic        core_target;
  logic        uart_src;
  logic        adc_src;
  logic [8:0]  core_step;
  logic [8:0]  uart_step;
  logic [8:0]  adc_step;

  assign wr_core   = ce_in && bus_in.wr && bus_in.addr == OFS_CORE_SEL;
  assign wr_unlock = ce_in && bus_in.wr && bus_in.addr == OFS_UNLOCK;
  assign unlocked  = lock_q == OPEN;
  assign core_req  = bus_in.wdata[2:0];

  assign synth_ref = synth_q[REF_SEL_BIT] ? level_in.fast
                                          : level_in.crystal;
  assign synth_lvl = synth_q[GATE_BIT] ? 1'b0 :
                     synth_q[PASS_BIT] ? synth_ref :
                     level_in.synth;

  // Stability of the requested core source
  assign req_ok = sel3(core_req, stable_in.crystal, stable_in.synth,
                       stable_in.slow, stable_in.fast);
  assign fail_set = wr_core && unlocked && core_req != 3'h1 &&
                    !req_ok;

  assign core_src = sel3(core_active_q, level_in.crystal, synth_lvl,
                         level_in.slow, level_in.fast);
  assign core_target = sel3(core_sel_q[2:0], level_in.crystal, synth_lvl,
                            level_in.slow, level_in.fast);
  assign uart_src = sel2(pa_q[25:24], level_in.crystal, synth_lvl,
                         level_in.fast, level_in.fast);
  assign adc_src = sel2(pa_q[3:2], level_in.crystal, synth_lvl,
                        level_in.fast, level_in.fast);

  assign core_step = div_step(core_src && !core_src_prev_q, core_cnt_q,
                              8'(div_q[CORE_DIV_W-1:0]));
  assign uart_step = div_step(uart_src && !uart_src_prev_q, uart_cnt_q,
                              8'(div_q[8 +: UART_DIV_W]));
  assign adc_step = div_step(adc_src && !adc_src_prev_q, adc_cnt_q,
                             8'(div_q[16 +: ADC_DIV_W]));

  // Unlock key sequence; stray writes relock, a first key always restarts
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lock_q <= LOCKED;
    end else if (wr_unlock) begin
      case (lock_q)
        LOCKED: begin
          lock_q <= bus_in.wdata[7:0] == UNLOCK_KEY_1 ? GOT_KEY_1 : LOCKED;
        end
        GOT_KEY_1: begin
          lock_q <= bus_in.wdata[7:0] == UNLOCK_KEY_2 ? GOT_KEY_2 :
                    bus_in.wdata[7:0] == UNLOCK_KEY_1 ? GOT_KEY_1 : LOCKED;
        end
        GOT_KEY_2: begin
          lock_q <= bus_in.wdata[7:0] == UNLOCK_KEY_3 ? OPEN :
                    bus_in.wdata[7:0] == UNLOCK_KEY_1 ? GOT_KEY_1 : LOCKED;
        end
        default: begin
          lock_q <= bus_in.wdata[7:0] == UNLOCK_KEY_1 ? GOT_KEY_1 : LOCKED;
        end
      endcase
    end
  end

  // Protected tick and core fields, strap capture after reset release
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      core_sel_q  <= SEL_RESET[5:0];
      boot_done_q <= 1'b0;
    end else if (ce_in) begin
      if (!boot_done_q) begin
        core_sel_q[2:0] <= boot_oscillator_config_in;
        boot_done_q     <= 1'b1;
      end else if (wr_core && unlocked) begin
        core_sel_q[5:3] <= bus_in.wdata[5:3];
        if (core_req != 3'h1 && req_ok) begin
          core_sel_q[2:0] <= core_req;
        end
      end
    end
  end

  // Failure flag: set wins over the write-one clear
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fail_q <= 1'b0;
    end else if (fail_set) begin
      fail_q <= 1'b1;
    end else if (ce_in && bus_in.wr && bus_in.addr == OFS_STABILITY &&
                 bus_in.wdata[FAIL_BIT]) begin
      fail_q <= 1'b0;
    end
  end

  // Peripheral, divider and synthesizer registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pa_q    <= SEL_RESET & PA_MASK;
      pb_q    <= SEL_RESET & PB_MASK;
      div_q   <= DIV_RESET;
      synth_q <= SYNTH_RESET;
    end else if (ce_in && bus_in.wr) begin
      if (bus_in.addr == OFS_PERIPH_A) begin
        pa_q[31:2] <= bus_in.wdata[31:2] & PA_MASK[31:2];
        if (unlocked) begin
          pa_q[1:0] <= bus_in.wdata[1:0];
        end
      end else if (bus_in.addr == OFS_PERIPH_B) begin
        pb_q <= bus_in.wdata & PB_MASK;
      end else if (bus_in.addr == OFS_DIVIDE) begin
        div_q <= bus_in.wdata & DIV_MASK;
      end else if (bus_in.addr == OFS_SYNTH) begin
        synth_q <= bus_in.wdata & SYNTH_MASK;
      end
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 32'h00000000;
    end else if (ce_in) begin
      rd_data_out <= 32'h00000000;
      if (bus_in.rd) begin
        if (bus_in.addr == OFS_STABILITY) begin
          rd_data_out[FAIL_BIT]      <= fail_q;
          rd_data_out[FAST_STB_BIT]  <= stable_in.fast;
          rd_data_out[SLOW_STB_BIT]  <= stable_in.slow;
          rd_data_out[SYNTH_STB_BIT] <= stable_in.synth;
          rd_data_out[XTAL_STB_BIT]  <= stable_in.crystal;
        end else if (bus_in.addr == OFS_CORE_SEL) begin
          rd_data_out[5:0] <= core_sel_q;
        end else if (bus_in.addr == OFS_PERIPH_A) begin
          rd_data_out <= pa_q;
        end else if (bus_in.addr == OFS_DIVIDE) begin
          rd_data_out <= div_q;
        end else if (bus_in.addr == OFS_PERIPH_B) begin
          rd_data_out <= pb_q;
        end else if (bus_in.addr == OFS_SYNTH) begin
          rd_data_out <= synth_q;
        end else if (bus_in.addr == OFS_UNLOCK) begin
          rd_data_out[0] <= unlocked;
        end
      end
    end
  end

  // Core switch waits until old and new sources are both low
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      core_active_q <= CORE_RESET;
      core_clk_out  <= 1'b0;
    end else if (ce_in) begin
      if (core_active_q != core_sel_q[2:0] && !core_src && !core_target) begin
        core_active_q <= core_sel_q[2:0];
      end
      core_clk_out <= core_src;
    end
  end

  // Edge history and half-rate clocks
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q          <= '0;
      core_src_prev_q <= 1'b0;
      uart_src_prev_q <= 1'b0;
      adc_src_prev_q  <= 1'b0;
      xtal_half_q     <= 1'b0;
      fast_half_q     <= 1'b0;
      core_half_q     <= 1'b0;
    end else if (ce_in) begin
      prev_q          <= level_in;
      core_src_prev_q <= core_src;
      uart_src_prev_q <= uart_src;
      adc_src_prev_q  <= adc_src;
      if (level_in.crystal && !prev_q.crystal) begin
        xtal_half_q <= !xtal_half_q;
      end
      if (level_in.fast && !prev_q.fast) begin
        fast_half_q <= !fast_half_q;
      end
      if (core_step[8]) begin
        core_half_q <= !core_half_q;
      end
    end
  end

  // Dividers; the core tick is the divided core clock
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      core_cnt_q    <= 8'h00;
      uart_cnt_q    <= 8'h00;
      adc_cnt_q     <= 8'h00;
      core_tick_out <= 1'b0;
      uart_tick_out <= 1'b0;
      adc_tick_out  <= 1'b0;
    end else if (ce_in) begin
      core_cnt_q    <= core_step[7:0];
      uart_cnt_q    <= uart_step[7:0];
      adc_cnt_q     <= adc_step[7:0];
      core_tick_out <= core_step[8];
      uart_tick_out <= uart_step[8];
      adc_tick_out  <= adc_step[8];
    end
  end

  // Watchdog core/2048: toggle every half period of core ticks
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wdog_cnt_q <= 10'h000;
      wdog_lvl_q <= 1'b0;
    end else if (ce_in && core_step[8]) begin
      wdog_cnt_q <= 10'(wdog_cnt_q + 10'h001);
      if (wdog_cnt_q == 10'(WDOG_DIVIDE / 2 - 1)) begin
        wdog_lvl_q <= !wdog_lvl_q;
      end
    end
  end

  // Engine clock selections
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tick_clk_out     <= 1'b0;
      pwm_clk_out      <= 4'h0;
      timer_clk_out    <= 4'h0;
      watchdog_clk_out <= 1'b0;
      freq_div_clk_out <= 1'b0;
    end else if (ce_in) begin
      tick_clk_out <= sel3(core_sel_q[5:3], level_in.crystal, xtal_half_q,
                           core_half_q, fast_half_q);
      pwm_clk_out[0] <= sel2(pa_q[29:28], level_in.crystal, 1'b0,
                             core_tick_out, level_in.fast);
      pwm_clk_out[1] <= sel2(pa_q[31:30], level_in.crystal, 1'b0,
                             core_tick_out, level_in.fast);
      pwm_clk_out[2] <= sel2(pb_q[5:4], level_in.crystal, 1'b0,
                             core_tick_out, level_in.fast);
      pwm_clk_out[3] <= sel2(pb_q[7:6], level_in.crystal, 1'b0,
                             core_tick_out, level_in.fast);
      for (int i = 0; i < 4; i++) begin
        timer_clk_out[i] <= sel3(pa_q[8 + 4 * i +: 3], level_in.crystal,
                                 core_tick_out, ext_trigger_in[i],
                                 level_in.fast);
      end
      watchdog_clk_out <= sel2(pa_q[1:0], level_in.crystal, 1'b0,
                               wdog_lvl_q, level_in.slow);
      freq_div_clk_out <= sel2(pb_q[3:2], level_in.crystal, 1'b0,
                               core_tick_out, level_in.fast);
    end
  end

  // Synthesizer controls and divider factors
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      synth_ref_clk_out    <= 1'b0;
      synth_clk_out        <= 1'b0;
      synth_sleep_out      <= 1'b0;
      synth_fb_factor_out  <= 10'h000;
      synth_in_factor_out  <= 6'h00;
      synth_out_factor_out <= 3'h0;
    end else if (ce_in) begin
      synth_ref_clk_out <= synth_ref;
      synth_clk_out     <= synth_lvl;
      synth_sleep_out   <= synth_q[SLEEP_BIT] || chip_sleep_req_in;
      synth_fb_factor_out <= 10'({1'b0, synth_q[8:0]} + 10'h002);
      synth_in_factor_out <= 6'({1'b0, synth_q[13:9]} + 6'h02);
      synth_out_factor_out <= synth_q[15:14] == 2'h0 ? 3'h1 :
                              synth_q[15:14] == 2'h3 ? 3'h4 : 3'h2;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_unlock;
    wr_unlock && bus_in.wdata[7:0] == UNLOCK_KEY_1 ##1
    wr_unlock && bus_in.wdata[7:0] == UNLOCK_KEY_2 ##1
    wr_unlock && bus_in.wdata[7:0] == UNLOCK_KEY_3;
  endsequence

  sequence s_bad_switch;
    wr_core && unlocked && core_req != 3'h1 && !req_ok;
  endsequence

  a_unlock_opens: assert property (s_unlock |=> unlocked)
    else $error("unlock sequence did not open protection");
  a_locked_hold: assert property (
      wr_core && !unlocked && boot_done_q |=> $stable(core_sel_q))
    else $error("locked core select changed");
  a_fail_sets: assert property (s_bad_switch |=> fail_q ##1 fail_q)
    else $error("switch failure flag not set");
  a_fail_clears: assert property (
      ce_in && bus_in.wr && !fail_set && bus_in.addr == OFS_STABILITY &&
      bus_in.wdata[FAIL_BIT] |=> !fail_q)
    else $error("switch failure flag not cleared");
  a_fail_keeps: assert property (
      (s_bad_switch and boot_done_q) |=> $stable(core_sel_q[2:0]))
    else $error("core source changed on failed switch");
  a_glitch_free: assert property (
      $changed(core_active_q) |-> !$past(core_src) && $past(ce_in))
    else $error("core source switched while high");
  a_stable_read: assert property (
      ce_in && bus_in.rd && bus_in.addr == OFS_STABILITY |=>
      rd_data_out[FAST_STB_BIT] == $past(stable_in.fast) &&
      rd_data_out[XTAL_STB_BIT] == $past(stable_in.crystal))
    else $error("stability flags read wrong");
  a_gate_low: assert property (
      ce_in && synth_q[GATE_BIT] |=> !synth_clk_out)
    else $error("gated synthesizer output not low");
  a_sleep_out: assert property (
      ce_in && chip_sleep_req_in |=> synth_sleep_out)
    else $error("synthesizer not asleep on chip request");
  a_fb_factor: assert property (
      ce_in |=> synth_fb_factor_out ==
      10'($past(synth_q[8:0])) + 10'h002)
    else $error("feedback factor wrong");
  a_div_wrap: assert property (
      core_tick_out |-> core_cnt_q == 8'h00)
    else $error("core divider tick without wrap");

endmodule
`default_nettype wire

// ===== tb/clock_source_select_divide_pll_tb_top.sv
// Self-checking bench for the clock select, divider and synthesizer block
`timescale 1ns/10ps
`default_nettype none
module clock_source_select_divide_pll_tb_top
  import cksel_pkg::*;
;
  logic          clk;
  logic          rst;
  cksel_bus_type bus;
  cksel_src_type lvl;
  cksel_src_type stb;
  logic          sleep_req;
  logic [31:0]   rdat;
  logic          s_clk;
  logic          s_ref;
  logic          s_sleep;
  logic [9:0]    s_fb;
  logic [5:0]    s_in;
  logic [2:0]    s_out;
  logic [3:0]    lv;
  logic [3:0]    trig;
  logic [2:0]    boot_cfg;
  cksel_src_type lvl_d;
  logic          c_clk;
  logic          c_tick;
  logic          t_clk;
  logic          u_tick;
  logic          a_tick;
  logic [3:0]    p_clk;
  logic [3:0]    tm_clk;
  logic          w_clk;
  logic          f_clk;
  int            err_total;
  int            check_count;
  int            cyc;

  cksel_top i_dut (
    .clock_in(clk), .rst_in(rst), .ce_in(1'b1), .bus_in(bus),
    .level_in(lvl), .stable_in(stb), .ext_trigger_in(trig),
    .chip_sleep_req_in(sleep_req), .boot_oscillator_config_in(boot_cfg),
    .rd_data_out(rdat), .core_clk_out(c_clk), .core_tick_out(c_tick),
    .tick_clk_out(t_clk), .uart_tick_out(u_tick), .adc_tick_out(a_tick),
    .pwm_clk_out(p_clk), .timer_clk_out(tm_clk),
    .watchdog_clk_out(w_clk), .freq_div_clk_out(f_clk),
    .synth_ref_clk_out(s_ref), .synth_clk_out(s_clk),
    .synth_sleep_out(s_sleep), .synth_fb_factor_out(s_fb),
    .synth_in_factor_out(s_in), .synth_out_factor_out(s_out));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Toggling source levels so the selected paths have edges to pass
  always @(posedge clk) begin
    lv <= lv + 4'h1;
    lvl <= {lv[0], lv[1], lv[2], lv[3]};
    lvl_d <= lvl;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // Three key writes back to back
  task automatic unlock();
    @(posedge clk);
    bus <= '{addr: OFS_UNLOCK, wdata: 32'h59, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wdata <= 32'h00000016;
    @(posedge clk);
    bus.wdata <= 32'h00000088;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk("read data", rdat, exp);
    @(posedge clk);
    #1 chk("read data after", rdat, 32'h0);
  endtask

  task automatic reset_values();
    rd_chk(OFS_CORE_SEL, 32'h00000038);
    rd_chk(OFS_PERIPH_A, 32'hF377770F);
    rd_chk(OFS_PERIPH_B, 32'h000000FC);
    rd_chk(OFS_DIVIDE, 32'h00000000);
    rd_chk(OFS_SYNTH, 32'h0005C22E);
    rd_chk(8'h28, 32'h00000000);
    rd_chk(OFS_STABILITY, 32'h0000001D);
    chk("factors", {s_fb, s_in, s_out}, {10'h030, 6'h03, 3'h4});
  endtask

  task automatic protect_and_switch();
    wr(OFS_CORE_SEL, 32'h0000003C);
    wr(OFS_PERIPH_A, 32'h00000000);
    rd_chk(OFS_CORE_SEL, 32'h00000038);
    rd_chk(OFS_PERIPH_A, 32'h00000003);
    unlock();
    rd_chk(OFS_UNLOCK, 32'h00000001);
    stb <= 4'b1110;
    wr(OFS_CORE_SEL, 32'h0000003A);
    rd_chk(OFS_CORE_SEL, 32'h00000038);
    rd_chk(OFS_STABILITY, 32'h00000099);
    wr(OFS_STABILITY, 32'h00000080);
    rd_chk(OFS_STABILITY, 32'h00000019);
    stb <= 4'b1111;
    wr(OFS_CORE_SEL, 32'h0000003A);
    rd_chk(OFS_CORE_SEL, 32'h0000003A);
    wr(OFS_PERIPH_A, 32'h00000002);
    rd_chk(OFS_PERIPH_A, 32'h00000002);
  endtask

  task automatic synth_control();
    wr(OFS_SYNTH, 32'h000D7FFF);
    repeat (3) @(posedge clk);
    #1 chk("factors", {s_fb, s_in, s_out}, {10'h201, 6'h21, 3'h2});
    chk("sleep bit", s_sleep, 1'b1);
    repeat (8) begin
      @(posedge clk);
      #1 chk("gated output", s_clk, 1'b0);
    end
    wr(OFS_SYNTH, 32'h000A0000);
    sleep_req <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("chip sleep", s_sleep, 1'b1);
    repeat (4) begin
      @(posedge clk);
      #1 chk("fast reference", s_ref, lvl_d.fast);
      chk("bypass passes ref", s_clk, lvl_d.fast);
    end
    wr(OFS_SYNTH, 32'h00020000);
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("awake", s_sleep, 1'b0);
    repeat (4) begin
      @(posedge clk);
      #1 chk("crystal reference", s_ref, lvl_d.crystal);
      chk("bypass crystal", s_clk, lvl_d.crystal);
    end
    wr(OFS_SYNTH, 32'h00000000);
    repeat (3) @(posedge clk);
    #1 chk("factors", {s_fb, s_in, s_out}, {10'h002, 6'h02, 3'h1});
    repeat (16) begin
      @(posedge clk);
      #1 chk("normal output", s_clk, lvl_d.synth);
    end
  endtask

  // Engine clock picks and divider tick rates
  task automatic engine_select();
    int n_core;
    int n_uart;
    int n_adc;
    wr(OFS_PERIPH_A, 32'h30104307);
    wr(OFS_PERIPH_B, 32'h00000070);
    wr(OFS_CORE_SEL, 32'h00000002);
    wr(OFS_DIVIDE, 32'h00010200);
    repeat (4) @(posedge clk);
    n_core = 0;
    n_uart = 0;
    n_adc = 0;
    repeat (96) begin
      @(posedge clk);
      #1 n_core += c_tick;
      n_uart += u_tick;
      n_adc += a_tick;
    end
    chk("core ticks", n_core, 6);
    chk("uart ticks", n_uart, 16);
    chk("adc ticks", n_adc, 3);
    repeat (8) begin
      @(posedge clk);
      #1 chk("pwm clocks", p_clk,
             {1'b0, lvl_d.fast, lvl_d.crystal, lvl_d.fast});
      chk("timer clocks", tm_clk,
          {1'b0, lvl_d.crystal, lvl_d.fast, trig[0]});
      chk("watchdog clock", w_clk, lvl_d.slow);
      chk("divider clock", f_clk, lvl_d.crystal);
      chk("tick clock", t_clk, lvl_d.crystal);
      chk("core clock", c_clk, lvl_d.synth);
    end
  endtask

  // Mid-run reset with the other boot strap value
  task automatic reboot();
    @(posedge clk);
    boot_cfg <= 3'h7;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(OFS_CORE_SEL, 32'h0000003F);
    rd_chk(OFS_UNLOCK, 32'h00000000);
  endtask

  initial begin
    err_total = 0;
    check_count = 0;
    cyc = 0;
    lv = 4'h0;
    lvl = '0;
    lvl_d = '0;
    trig = 4'h1;
    boot_cfg = 3'h0;
    stb = 4'b1111;
    sleep_req = 1'b0;
    bus = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    reset_values();
    protect_and_switch();
    synth_control();
    engine_select();
    reboot();
    end_of_test();
  end
endmodule
`default_nettype wire
